//--- rtcps_consts.vh
/*
 * constants of the rtc power-on and backup sequencer: register offsets,
 * field positions, reset values, time figures and oscillator increments.
 * assumes a 100 MHz system clock; times are kept in microseconds.
 */
`ifndef RTCPS_CONSTS_VH
`define RTCPS_CONSTS_VH

// system clock rate
`define RTCPS_CLK_MHZ        100

// time figures in microseconds
`define RTCPS_T_POR_US       6000
`define RTCPS_T_START_US     100000
`define RTCPS_T_DLY_32K_US   950
`define RTCPS_T_DLY_1K_US    1280
`define RTCPS_T_DLY_64_US    6650
`define RTCPS_T_DLY_1HZ_US   999000
`define RTCPS_T_DLY_HF_US    950
`define RTCPS_T_DSM_US       2000
`define RTCPS_T_LSM_US       10000
`define RTCPS_T_DEB_US       1000
`define RTCPS_T_SAMPLE_US    1000000

// register offsets
`define RTCPS_A_STATUS       8'h00
`define RTCPS_A_MASK         8'h01
`define RTCPS_A_CLKCFG       8'h02
`define RTCPS_A_HFD_LO       8'h03
`define RTCPS_A_HFD_HI       8'h04
`define RTCPS_A_BACKUP       8'h05
`define RTCPS_A_STATE        8'h06

// status and mask fields
`define RTCPS_B_POF          0
`define RTCPS_B_LVF          1

// clock configuration fields
`define RTCPS_B_DIS          0
`define RTCPS_B_OS           1
`define RTCPS_B_FD_LO        2
`define RTCPS_B_FD_HI        3
`define RTCPS_B_CKF          4

// low frequency encodings
`define RTCPS_FD_32K         2'h0
`define RTCPS_FD_1K          2'h1
`define RTCPS_FD_64          2'h2
`define RTCPS_FD_1HZ         2'h3

// backup switchover modes
`define RTCPS_BSM_OFF        2'h0
`define RTCPS_BSM_DSM        2'h1
`define RTCPS_BSM_LSM        2'h2

// reset values
`define RTCPS_RST_STATUS     2'h1
`define RTCPS_RST_MASK       2'h0
`define RTCPS_RST_CLKCFG     5'h00
`define RTCPS_RST_HFD        13'h0000

// phase increments for a 32-bit accumulator at 100 MHz
`define RTCPS_INC_32K        32'h0015_798f
`define RTCPS_INC_1K         32'h0000_abcc
`define RTCPS_INC_64         32'h0000_0abd
`define RTCPS_INC_1HZ        32'h0000_002b
`define RTCPS_INC_HF_STEP    19'h55e64

`endif

//--- rtcps_clkgen.v
/*
 * square wave generator for the clock output: a 32-bit phase accumulator
 * on the system clock, step chosen by the frequency fields.
 * assumes settings come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "rtcps_consts.vh"

module rtcps_clkgen (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        oscillator_select,
  input  wire [1:0]  low_freq_select,
  input  wire [12:0] high_freq_divider,
  output reg         wave,
  output reg         wave_rise
);

  reg  [31:0] phase;
  reg  [31:0] step;
  wire [32:0] hf_prod;
  wire [31:0] next_phase;

  // high range is 8.192 kHz times (divider + 1); above 50 MHz it aliases
  assign hf_prod    = {6'h00, ({1'b0, high_freq_divider} + 14'h0001)} * {14'h0000, `RTCPS_INC_HF_STEP};
  assign next_phase = phase + step;

  // step select
  always @* begin
    step = `RTCPS_INC_32K;
    if (oscillator_select) begin
      step = hf_prod[31:0];
    end else begin
      case (low_freq_select)
        `RTCPS_FD_1K:  step = `RTCPS_INC_1K;
        `RTCPS_FD_64:  step = `RTCPS_INC_64;
        `RTCPS_FD_1HZ: step = `RTCPS_INC_1HZ;
        default:       step = `RTCPS_INC_32K;
      endcase
    end
  end

  // accumulator; msb is the wave, its rising edge a pulse
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase     <= 32'h0000_0000;
      wave      <= 1'b0;
      wave_rise <= 1'b0;
    end else begin
      phase     <= next_phase;
      wave      <= next_phase[31];
      wave_rise <= next_phase[31] & ~wave;
    end
  end

endmodule

//--- rtcps_top.v
/*
 * power-on and backup sequencer of a temperature compensated rtc:
 * power-on reset window, clock output control, power-on flag and
 * interrupt, reduced-supply state, switchover activation and debounce.
 * assumes supply detector levels and the stored interrupt enable arrive
 * from outside the clock domain; rst models the power-on reset itself.
 */
// How it works
// R1: clock pin hi-z during por, then low
// R2: set power-on flag on por detection
// R3: stored enable copied after start-up, interrupt asserts
// R4: selectable low or stepped high frequencies
// R5: disable with flag clear holds pin low
// R6: enable after frequency-dependent synchronized delay
// R7: power-on flag sticky until software clears
// R8: interrupt released when power-on flag cleared
// R9: reduced supply keeps clocks, registers, sampling
// R10: reduced supply stops compensation, output, bus
// R11: host reinitializes registers after reduced supply
// R12: switchover active within 2 or 10 ms
// R13: return debounce 1 ms, or 1 Hz sampling
// R14: host polls acknowledge or waits interrupt
// R15: low-voltage flag sticky on low sample
`timescale 1ns/1ps
`include "rtcps_consts.vh"

module rtcps_top #(
  parameter [26:0] P_POR_CYC    = `RTCPS_T_POR_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_START_CYC  = `RTCPS_T_START_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_DLY_32K    = `RTCPS_T_DLY_32K_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_DLY_1K     = `RTCPS_T_DLY_1K_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_DLY_64     = `RTCPS_T_DLY_64_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_DLY_1HZ    = `RTCPS_T_DLY_1HZ_US * `RTCPS_CLK_MHZ,
  // dependent times scale with their base, so one override shortens the base and every time derived from it
  parameter [26:0] P_DLY_HF     = P_DLY_32K * `RTCPS_T_DLY_HF_US / `RTCPS_T_DLY_32K_US,
  parameter [26:0] P_DSM_CYC    = `RTCPS_T_DSM_US * `RTCPS_CLK_MHZ,
  parameter [26:0] P_LSM_CYC    = P_DSM_CYC * `RTCPS_T_LSM_US / `RTCPS_T_DSM_US,
  parameter [26:0] P_DEB_CYC    = P_DSM_CYC * `RTCPS_T_DEB_US / `RTCPS_T_DSM_US,
  parameter [26:0] P_SAMPLE_CYC = `RTCPS_T_SAMPLE_US * `RTCPS_CLK_MHZ
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       supply_below_por,
  input  wire       supply_below_low,
  input  wire       on_backup_supply,
  input  wire       nv_power_on_irq_enable,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        irq_n,
  output reg        clock_output_pin,
  output reg        clock_output_oe,
  output reg        temp_comp_enable,
  output reg        bus_enable,
  output reg        switchover_active,
  output reg        supply_on_main
);

  localparam [2:0] ST_POR   = 3'b001;
  localparam [2:0] ST_START = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  reg  [3:0]  sync_a;
  reg  [3:0]  sync_b;
  reg  [2:0]  state;
  reg  [26:0] seq_cnt;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [4:0]  clkcfg;
  reg  [12:0] high_freq_divider;
  reg  [1:0]  backup_mode;
  reg  [26:0] act_cnt;
  reg  [26:0] dly_cnt;
  reg  [26:0] deb_cnt;
  reg  [26:0] smp_cnt;
  reg         clk_running;
  reg         reduced;
  reg  [7:0]  next_rdata;
  wire        below_por;
  wire        below_low;
  wire        on_backup;
  wire        nv_irq_en;
  wire        wr_ok;
  wire        rd_ok;
  wire        cfg_wr;
  wire        bsm_wr;
  wire        want_clk;
  wire        sample_tick;
  wire        wave;
  wire        wave_rise;
  wire [1:0]  events;
  wire [1:0]  next_status;
  wire [26:0] dly_target;

  // delay target per selected frequency
  function [26:0] delay_for;
    input       os;
    input [1:0] fd;
    begin
      if (os) begin
        delay_for = P_DLY_HF;
      end else begin
        case (fd)
          `RTCPS_FD_1K:  delay_for = P_DLY_1K;
          `RTCPS_FD_64:  delay_for = P_DLY_64;
          `RTCPS_FD_1HZ: delay_for = P_DLY_1HZ;
          default:       delay_for = P_DLY_32K;
        endcase
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers; only sync_b is read by logic
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {nv_power_on_irq_enable, on_backup_supply, supply_below_low, supply_below_por};
      sync_b <= sync_a;
    end
  end

  assign below_por = sync_b[0];
  assign below_low = sync_b[1];
  assign on_backup = sync_b[2];
  assign nv_irq_en = sync_b[3];

  //////////////////////////////////////////////////////////////////////////
  // power-on sequence: por window, then start-up, then running
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state   <= ST_POR;
      seq_cnt <= 27'h0000000;
    end else begin
      case (state)
        ST_POR: begin
          seq_cnt <= seq_cnt + 27'h0000001;
          if (seq_cnt == P_POR_CYC - 27'h0000001) begin
            state <= ST_START; // R1
          end
        end
        ST_START: begin
          seq_cnt <= seq_cnt + 27'h0000001;
          if (seq_cnt == P_START_CYC - 27'h0000001) begin
            state <= ST_RUN; // R3
          end
        end
        ST_RUN: begin
          seq_cnt <= seq_cnt;
        end
        default: begin
          state <= ST_POR;
        end
      endcase
    end
  end

  // reduced supply: low-voltage detected while still above por level
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reduced <= 1'b0;
    end else begin
      reduced <= below_low & ~below_por; // R9
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register port; bus is dead before the por window ends and when reduced
  assign wr_ok  = reg_wr & bus_enable;
  assign rd_ok  = reg_rd & bus_enable;
  assign cfg_wr = wr_ok & ((reg_addr == `RTCPS_A_CLKCFG) | (reg_addr == `RTCPS_A_HFD_LO) |
                           (reg_addr == `RTCPS_A_HFD_HI));
  assign bsm_wr = wr_ok & (reg_addr == `RTCPS_A_BACKUP);

  // sticky events: hardware set wins over a write-one clear in the same cycle
  assign events      = {below_low, below_por}; // R2 R15
  assign next_status = (wr_ok && reg_addr == `RTCPS_A_STATUS) ?
                       ((status & ~reg_wdata[1:0]) | events) : (status | events); // R7

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status            <= `RTCPS_RST_STATUS; // R2
      mask              <= `RTCPS_RST_MASK;
      clkcfg            <= `RTCPS_RST_CLKCFG;
      high_freq_divider <= `RTCPS_RST_HFD;
    end else begin
      status <= next_status; // R7 R15
      if (wr_ok && reg_addr == `RTCPS_A_MASK) begin
        mask <= reg_wdata[1:0];
      end else if (state == ST_START && seq_cnt == P_START_CYC - 27'h0000001 && nv_irq_en) begin
        mask[`RTCPS_B_POF] <= 1'b1; // R3
      end
      if (wr_ok && reg_addr == `RTCPS_A_CLKCFG) begin
        clkcfg <= reg_wdata[4:0];
      end
      if (wr_ok && reg_addr == `RTCPS_A_HFD_LO) begin
        high_freq_divider[7:0] <= reg_wdata;
      end
      if (wr_ok && reg_addr == `RTCPS_A_HFD_HI) begin
        high_freq_divider[12:8] <= reg_wdata[4:0];
      end
    end
  end

  // read mux; unmapped or refused reads return zero
  always @* begin
    next_rdata = 8'h00;
    if (rd_ok) begin
      case (reg_addr)
        `RTCPS_A_STATUS: next_rdata = {6'h00, status};
        `RTCPS_A_MASK:   next_rdata = {6'h00, mask};
        `RTCPS_A_CLKCFG: next_rdata = {3'h0, clkcfg};
        `RTCPS_A_HFD_LO: next_rdata = high_freq_divider[7:0];
        `RTCPS_A_HFD_HI: next_rdata = {3'h0, high_freq_divider[12:8]};
        `RTCPS_A_BACKUP: next_rdata = {6'h00, backup_mode};
        `RTCPS_A_STATE:  next_rdata = {2'h0, (state != ST_POR), (state == ST_RUN), clk_running,
                                       supply_on_main, switchover_active, reduced};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus, interrupt and compensation outputs
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata        <= 8'h00;
      irq_n            <= 1'b1;
      bus_enable       <= 1'b0;
      temp_comp_enable <= 1'b0;
    end else begin
      reg_rdata        <= next_rdata;
      irq_n            <= ~|(next_status & mask); // R3 R8
      bus_enable       <= (state != ST_POR) & ~(below_low & ~below_por); // R10
      temp_comp_enable <= (state == ST_RUN) & ~(below_low & ~below_por); // R10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock output: generator, synchronized enable delay and pin
  rtcps_clkgen u_clkgen (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .oscillator_select (clkcfg[`RTCPS_B_OS]),
    .low_freq_select   (clkcfg[`RTCPS_B_FD_HI:`RTCPS_B_FD_LO]),
    .high_freq_divider (high_freq_divider),
    .wave              (wave),
    .wave_rise         (wave_rise)
  ); // R4

  assign want_clk   = (state != ST_POR) & ~reduced &
                      ~(clkcfg[`RTCPS_B_DIS] & ~clkcfg[`RTCPS_B_CKF]); // R5 R10
  assign dly_target = delay_for(clkcfg[`RTCPS_B_OS], clkcfg[`RTCPS_B_FD_HI:`RTCPS_B_FD_LO]);

  // a config change restarts the delay and drops the pin at once; it comes back on the first wave rise after the delay
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dly_cnt     <= 27'h0000000;
      clk_running <= 1'b0;
    end else if (!want_clk || cfg_wr) begin
      dly_cnt     <= 27'h0000000;
      clk_running <= 1'b0;
    end else if (!clk_running) begin
      if (dly_cnt < dly_target) begin
        dly_cnt <= dly_cnt + 27'h0000001;
      end else if (wave_rise) begin
        clk_running <= 1'b1; // R6
      end
    end
  end

  // pin: hi-z during por, low until running, then the wave
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_output_oe  <= 1'b0;
      clock_output_pin <= 1'b0;
    end else begin
      clock_output_oe  <= (state != ST_POR); // R1
      clock_output_pin <= clk_running & want_clk & wave; // R5 R10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // backup switchover activation after leaving the disabled mode
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      backup_mode       <= `RTCPS_BSM_OFF;
      act_cnt           <= 27'h0000000;
      switchover_active <= 1'b0;
    end else if (bsm_wr) begin
      backup_mode <= reg_wdata[1:0];
      if (reg_wdata[1:0] != `RTCPS_BSM_DSM && reg_wdata[1:0] != `RTCPS_BSM_LSM) begin
        switchover_active <= 1'b0;
        act_cnt           <= 27'h0000000;
      end else if (!switchover_active && act_cnt == 27'h0000000) begin
        act_cnt <= (reg_wdata[1:0] == `RTCPS_BSM_DSM) ? P_DSM_CYC : P_LSM_CYC; // R12
      end
    end else if (act_cnt != 27'h0000000) begin
      act_cnt <= act_cnt - 27'h0000001;
      if (act_cnt == 27'h0000001) begin
        switchover_active <= 1'b1; // R12
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // 1 Hz sampler; keeps running in reduced supply
  assign sample_tick = (smp_cnt == P_SAMPLE_CYC - 27'h0000001);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smp_cnt <= 27'h0000000;
    end else if (sample_tick) begin
      smp_cnt <= 27'h0000000;
    end else begin
      smp_cnt <= smp_cnt + 27'h0000001; // R9
    end
  end

  // return debounce: fixed time if no low voltage, else next 1 Hz sample
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deb_cnt        <= 27'h0000000;
      supply_on_main <= 1'b1;
    end else if (on_backup) begin
      deb_cnt        <= 27'h0000000;
      supply_on_main <= 1'b0;
    end else if (!supply_on_main) begin
      if (status[`RTCPS_B_LVF]) begin
        if (sample_tick && !below_low) begin
          supply_on_main <= 1'b1; // R13
        end
      end else if (deb_cnt == P_DEB_CYC - 27'h0000001) begin
        supply_on_main <= 1'b1; // R13
      end else begin
        deb_cnt <= deb_cnt + 27'h0000001;
      end
    end
  end

endmodule

//--- rtcps_top_assertions.sv
/* checker for the sequencer top: por window, interrupt release, refused
 * reads, reduced supply, output delays, switchover and debounce.
 * assumes a bind to rtcps_top with shortened counts. */
`timescale 1ns/1ps
`include "rtcps_consts.vh"
module rtcps_chk #(
  parameter [26:0] P_POR_CYC = 27'h14
) (
  input wire       clk_sys,
  input wire       rst,
  input wire       supply_below_por,
  input wire       supply_below_low,
  input wire       on_backup_supply,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       irq_n,
  input wire       clock_output_pin,
  input wire       clock_output_oe,
  input wire       temp_comp_enable,
  input wire       bus_enable,
  input wire       switchover_active,
  input wire       supply_on_main
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // cycles since release, saturating at the window length
  reg [26:0] por_cnt;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      por_cnt <= 27'h0;
    else if (por_cnt < P_POR_CYC)
      por_cnt <= por_cnt + 27'h1;
  end
  // quiet supply covers the two-stage input synchroniser
  sequence s_quiet; (!supply_below_por && !supply_below_low)[*4]; endsequence
  sequence s_clr_all; reg_wr && bus_enable && reg_addr == `RTCPS_A_STATUS && reg_wdata[1:0] == 2'h3; endsequence
  sequence s_cfg_wr; reg_wr && bus_enable && reg_addr == `RTCPS_A_CLKCFG; endsequence
  sequence s_reduced; (supply_below_low && !supply_below_por)[*4]; endsequence
  property p_por_hiz; (por_cnt < P_POR_CYC) |-> !clock_output_oe && !clock_output_pin; endproperty
  property p_pin_oe; !clock_output_oe |-> !clock_output_pin; endproperty
  property p_irq_rel; s_quiet ##0 s_clr_all |-> ##[1:2] irq_n; endproperty
  property p_por_flag; supply_below_por[*3] ##0 reg_rd && bus_enable && reg_addr == `RTCPS_A_STATUS |=> reg_rdata[0]; endproperty
  property p_refuse; !(reg_rd && bus_enable) |=> reg_rdata == 8'h00; endproperty
  property p_reduced; s_reduced |=> !bus_enable && !temp_comp_enable && !clock_output_pin; endproperty
  property p_comp_bus; temp_comp_enable |-> bus_enable; endproperty
  property p_dis_low; s_cfg_wr ##0 (reg_wdata[0] && !reg_wdata[4]) |-> ##3 !clock_output_pin[*6]; endproperty
  property p_en_dly; s_cfg_wr ##0 !reg_wdata[0] |=> !clock_output_pin[*8]; endproperty
  property p_swa_wait; reg_wr && bus_enable && reg_addr == `RTCPS_A_BACKUP && (reg_wdata[1] ^ reg_wdata[0])
    && !switchover_active |=> !switchover_active[*8]; endproperty
  property p_deb; on_backup_supply |-> ##4 !supply_on_main; endproperty
  a_por_hiz:  assert property (p_por_hiz) else $error("output driven in por window");
  a_pin_oe:   assert property (p_pin_oe) else $error("pin high while undriven");
  a_irq_rel:  assert property (p_irq_rel) else $error("irq held after flags cleared");
  a_por_flag: assert property (p_por_flag) else $error("power-on flag missing");
  a_refuse:   assert property (p_refuse) else $error("read data outside answer");
  a_reduced:  assert property (p_reduced) else $error("reduced state still active");
  a_comp_bus: assert property (p_comp_bus) else $error("compensation without bus");
  a_dis_low:  assert property (p_dis_low) else $error("disabled output toggles");
  a_en_dly:   assert property (p_en_dly) else $error("output before enable delay");
  a_swa_wait: assert property (p_swa_wait) else $error("switchover too early");
  a_deb:      assert property (p_deb) else $error("main supply flagged on backup");
endmodule

bind rtcps_top rtcps_chk #(.P_POR_CYC(P_POR_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .supply_below_por(supply_below_por), .supply_below_low(supply_below_low), .on_backup_supply(on_backup_supply),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_n(irq_n), .clock_output_pin(clock_output_pin), .clock_output_oe(clock_output_oe),
  .temp_comp_enable(temp_comp_enable), .bus_enable(bus_enable), .switchover_active(switchover_active),
  .supply_on_main(supply_on_main));

//--- rtcps_host.sv
/* host model on the register port: strobed accesses, bring-up polling
 * and register reinitialisation after a supply dip.
 * assumes the sequencer top on the same clock. */
`timescale 1ns/1ps
`include "rtcps_consts.vh"
module rtcps_host (
  input  wire       clk_sys,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released address and data are inverted so stale values never help
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
    end
  endtask
  // poll until the port answers; refused reads return zero
  task wait_ready(output ok);
    reg [7:0] d;
    integer   i;
    begin
      ok = 1'b0;
      for (i = 0; i < 100 && !ok; i = i + 1) begin
        rd(`RTCPS_A_STATE, d);
        ok = d[5];
      end
    end
  endtask
  // contents may be lost after a dip, so rewrite status, mask and clock configuration
  task reinit(input [7:0] mask);
    begin
      wr(`RTCPS_A_STATUS, 8'h03);
      wr(`RTCPS_A_MASK, mask);
      wr(`RTCPS_A_CLKCFG, 8'h00);
    end
  endtask
endmodule

//--- rtcps_tb.sv
/* self-checking bench of the sequencer top, driven through the host model.
 * assumes shortened counts and a 100 MHz clock. */
`timescale 1ns/1ps
`include "rtcps_consts.vh"
module testbench;
  reg        clk_sys, rst, below_por, below_low, on_backup, nv_en, ok;
  reg  [7:0] d;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire       reg_wr, reg_rd, irq_n, pin, oe, tcomp, bus_en, swa, on_main;
  wire [4:0] sigs = {bus_en, on_main, swa, ~irq_n, pin};
  integer    err_total, total_checks, n, h, i, e;
  ////////////////////////////////////////////////////////////
  // high-frequency delay, level switchover and debounce follow these inside the design
  rtcps_top #(.P_POR_CYC(27'h14), .P_START_CYC(27'h3c), .P_DLY_32K(27'h14),
    .P_DSM_CYC(27'h14)) dut (.clk_sys(clk_sys), .rst(rst),
    .supply_below_por(below_por), .supply_below_low(below_low), .on_backup_supply(on_backup),
    .nv_power_on_irq_enable(nv_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_n(irq_n), .clock_output_pin(pin), .clock_output_oe(oe),
    .temp_comp_enable(tcomp), .bus_enable(bus_en), .switchover_active(swa), .supply_on_main(on_main));
  rtcps_host u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  ////////////////////////////////////////////////////////////
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge clk_sys);
      #1;
    end
  endtask
  // bounded wait for one watched signal, then compare it
  task wait_hi(input integer s, input integer lim);
    begin
      n = 0;
      while (sigs[s] !== 1'b1 && n < lim) begin
        cyc(1);
        n = n + 1;
      end
      chk({7'h0, sigs[s]}, 8'h01);
    end
  endtask
  // rising edges into n, high samples into h
  task count_pin(input integer k);
    reg p;
    begin
      n = 0;
      h = 0;
      p = pin;
      repeat (k) begin
        cyc(1);
        if (pin === 1'b1 && p === 1'b0) n = n + 1;
        if (pin === 1'b1) h = h + 1;
        p = pin;
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // sized from roughly 10k cycles of tests, with twice that as margin
  initial begin
    #300000;
    err_total = err_total + 1;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
  // main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    {below_por, below_low, on_backup} = 3'h0;
    nv_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({4'h0, oe, pin, irq_n, on_main}, 8'h03);
    @(posedge clk_sys) rst <= 1'b0;
    cyc(15);
    chk({6'h0, oe, pin}, 8'h00);
    u_host.wait_ready(ok);
    chk({6'h0, oe, pin}, 8'h02);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d, 8'h01);
    u_host.rd(`RTCPS_A_MASK, d); chk(d, 8'h00);
    u_host.rd(`RTCPS_A_CLKCFG, d); chk(d, 8'h00);
    u_host.rd(8'h20, d); chk(d, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    wait_hi(1, 100);
    u_host.rd(`RTCPS_A_MASK, d); chk(d, 8'h01);
    wait_hi(0, 3400);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d, 8'h01);
    u_host.wr(`RTCPS_A_STATUS, 8'h01); cyc(3); chk({7'h0, irq_n}, 8'h01);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d, 8'h00);
    // disabled output with the flag clear stays low, with the flag set it runs
    u_host.wr(`RTCPS_A_CLKCFG, 8'h01); cyc(4); count_pin(3200); chk(h[7:0], 8'h00);
    u_host.wr(`RTCPS_A_CLKCFG, 8'h11); wait_hi(0, 3400);
    // every low frequency code holds the pin low for the first 18 to 30 cycles of its delay
    for (i = 0; i < 4; i = i + 1) begin
      u_host.wr(`RTCPS_A_CLKCFG, 8'h01); cyc(8);
      u_host.wr(`RTCPS_A_CLKCFG, {i[5:0], 2'h0}); count_pin(18 + 4 * i); chk(h[7:0], 8'h00);
    end
    // stepped high frequency: 8192 Hz times divider plus one
    for (i = 0; i < 2; i = i + 1) begin
      u_host.wr(`RTCPS_A_HFD_LO, 8'hff);
      u_host.wr(`RTCPS_A_HFD_HI, i ? 8'h01 : 8'h03);
      u_host.wr(`RTCPS_A_CLKCFG, 8'h02); cyc(60); count_pin(1200);
      e = (8192 * (i ? 512 : 1024) * 12) / 1000000;
      chk({7'h0, n >= e && n <= e + 1}, 8'h01);
    end
    // switchover activation, direct then level
    for (i = 1; i < 3; i = i + 1) begin
      u_host.wr(`RTCPS_A_BACKUP, i[7:0]); cyc(i == 1 ? 17 : 97); chk({7'h0, swa}, 8'h00);
      wait_hi(2, 10);
      u_host.wr(`RTCPS_A_BACKUP, 8'h00); cyc(2); chk({7'h0, swa}, 8'h00);
    end
    // return to main with the low-voltage flag clear
    @(posedge clk_sys) on_backup <= 1'b1; cyc(6); chk({7'h0, on_main}, 8'h00);
    @(posedge clk_sys) on_backup <= 1'b0; cyc(5); chk({7'h0, on_main}, 8'h00);
    wait_hi(3, 12);
    // reduced supply keeps registers, blocks the port and raises the flag
    u_host.wr(`RTCPS_A_MASK, 8'h03);
    @(posedge clk_sys) below_low <= 1'b1; cyc(6);
    chk({5'h0, bus_en, tcomp, pin}, 8'h00);
    chk({7'h0, irq_n}, 8'h00);
    u_host.rd(`RTCPS_A_MASK, d); chk(d, 8'h00);
    u_host.wr(`RTCPS_A_MASK, 8'h00);
    @(posedge clk_sys) below_low <= 1'b0; wait_hi(4, 200);
    u_host.rd(`RTCPS_A_MASK, d); chk(d, 8'h03);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d, 8'h02);
    u_host.reinit(8'h01); cyc(3); chk({7'h0, irq_n}, 8'h01);
    // a later power-on event sets the flag again
    @(posedge clk_sys) below_por <= 1'b1; cyc(5);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d & 8'h01, 8'h01);
    @(posedge clk_sys) below_por <= 1'b0; wait_hi(4, 200);
    u_host.rd(`RTCPS_A_STATUS, d); chk(d & 8'h01, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    u_host.wr(`RTCPS_A_STATUS, 8'h01); cyc(3); chk({7'h0, irq_n}, 8'h01);
    test_done;
  end
endmodule
